/* File: design/serial_boot_map.vh */
// constants of the serial boot RAM loader sequencer
`ifndef SERIAL_BOOT_MAP_VH
`define SERIAL_BOOT_MAP_VH

// =============================================
// matching bytes and command code
`define MATCH1_A 8'h86
`define MATCH1_B 8'h30
`define MATCH2_A 8'h79
`define MATCH2_B 8'hcf
`define CMD_RAM_LOAD 8'h60

// =============================================
// error codes, each sent three times
`define ERR_FRAME 8'ha1
`define ERR_OVERRUN 8'ha3
`define ERR_COMMAND 8'h63
`define ERR_REPEAT 2'h3

// =============================================
// password address fields: two 24-bit values
`define ADDR_BYTES 3'h6
`define ADDR_W 24

// =============================================
// binary hex record layout
`define REC_MARK 8'h3a
`define REC_TYPE_DATA 8'h00
`define REC_TYPE_END 8'h01
`define REC_POS_MARK 3'h0
`define REC_POS_LEN 3'h1
`define REC_POS_AHI 3'h2
`define REC_POS_ALO 3'h3
`define REC_POS_TYPE 3'h4
`define REC_POS_DATA 3'h5
`define REC_POS_SUM 3'h6

// =============================================
// transmit buffer shape
`define BYTE_W 8
`define TXQ_DEPTH 4
`define TXQ_AW 2

`endif

/* File: design/loader_txq.v */
// small byte fifo with valid and ready on both sides
module loader_txq #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// clock, reset, enable
	input wire clk_i,
	input wire rstn_i,
	input wire ce_i,
	// filling side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// draining side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// honest flags straight from the fill count
	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign out_valid_o = (count_reg != {(AW+1){1'b0}});
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = ce_i & in_valid_i & in_ready_o;
	assign pop = ce_i & out_ready_i & out_valid_o;

	// storage words, one write port each
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_word
			always @(posedge clk_i) begin
				if (push && wr_ptr_reg == g[AW-1:0]) begin
					mem_reg[g] <= in_data_i;
				end
			end
		end
	endgenerate

	// pointers and count
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

/* File: design/serial_boot_ram_loader.v */
// boot-mode byte sequencer for the serial RAM loader command
// =============================================
// Overview of operation
// - First byte must be a first matching value; it is echoed when good, otherwise nothing is sent.
// - Second byte must be a second matching value; it is echoed when good, otherwise nothing is sent.
// - Third byte is the RAM loader command code, echoed back when accepted.
// - A faulty command byte makes the block send one error code three times and then go idle.
// - Three bytes of password count storage address follow, high byte first, with no reply.
// - Three bytes of password comparison start address follow, high byte first, with no reply.
// - A clean image is answered with a 16-bit checksum, high byte first; an error sends nothing.
// - When loading is done the block jumps to the address of the first data byte written.
// - With an erased password area the password check is skipped and no string is expected.
// - Both address fields always come; a wrong one is a password error that makes the block go idle.
// - Security protection enabled or a password error stops the link and makes the block go idle.
// - A line error during the address fields or the password string makes the block go idle.
`include "serial_boot_map.vh"

module serial_boot_ram_loader (
	// clock, reset, enable
	input wire clk_i,
	input wire rstn_i,
	input wire ce_i,
	// received bytes from the serial receiver
	input wire rx_valid_i,
	input wire [7:0] rx_data_i,
	input wire rx_frame_err_i,
	input wire rx_overrun_err_i,
	output reg rx_ready_o,
	// bytes to the serial transmitter
	output reg tx_valid_o,
	output reg [7:0] tx_data_o,
	input wire tx_ready_i,
	// password area and protection state
	input wire blank_i,
	input wire secure_i,
	input wire [23:0] exp_cnt_addr_i,
	input wire [23:0] exp_cmp_addr_i,
	input wire [7:0] pwd_len_i,
	input wire [7:0] pwd_byte_i,
	output reg [7:0] pwd_idx_o,
	// RAM write port
	output reg ram_we_o,
	output reg [15:0] ram_addr_o,
	output reg [7:0] ram_wdata_o,
	// hand-off to loaded code
	output reg jump_o,
	output reg [15:0] jump_addr_o,
	output reg idle_o
);
	// =============================================
	// states
	localparam [3:0] S_SYNC1 = 4'h0;
	localparam [3:0] S_SYNC2 = 4'h1;
	localparam [3:0] S_CMD = 4'h2;
	localparam [3:0] S_ERR = 4'h3;
	localparam [3:0] S_ADDR = 4'h4;
	localparam [3:0] S_PWD = 4'h5;
	localparam [3:0] S_REC = 4'h6;
	localparam [3:0] S_SUMH = 4'h7;
	localparam [3:0] S_SUML = 4'h8;
	localparam [3:0] S_JUMP = 4'h9;
	localparam [3:0] S_IDLE = 4'ha;

	// =============================================
	// decode helpers
	// line error code chosen by the receiver flags
	function [7:0] line_err_code;
		input fe;
		input oe;
		begin
			if (fe) begin
				line_err_code = `ERR_FRAME;
			end else if (oe) begin
				line_err_code = `ERR_OVERRUN;
			end else begin
				line_err_code = `ERR_COMMAND;
			end
		end
	endfunction

	// state in which the sequencer takes bytes
	function takes_bytes;
		input [3:0] st;
		begin
			case (st)
				S_SYNC1, S_SYNC2, S_CMD, S_ADDR, S_PWD, S_REC: takes_bytes = 1'b1;
				default: takes_bytes = 1'b0;
			endcase
		end
	endfunction

	// =============================================
	// registers
	reg [3:0] state_reg;
	reg [2:0] cnt_reg;
	reg [47:0] addr_reg;
	reg [7:0] err_code_reg;
	reg [1:0] err_cnt_reg;
	reg push_v_reg;
	reg [7:0] push_d_reg;
	reg [2:0] rec_pos_reg;
	reg [7:0] rec_len_reg;
	reg [7:0] rec_cnt_reg;
	reg [15:0] rec_addr_reg;
	reg [7:0] rec_type_reg;
	reg [7:0] rec_sum_reg;
	reg [15:0] sum_reg;
	reg first_seen_reg;
	reg [15:0] start_addr_reg;

	// =============================================
	// transmit buffer
	wire q_in_ready;
	wire q_out_valid;
	wire [7:0] q_out_data;
	wire q_out_ready;
	wire acc;
	wire line_err;
	wire push_done;
	wire [7:0] rec_sum_next;

	// the output stage takes a word when empty or being emptied
	assign q_out_ready = !tx_valid_o || tx_ready_i;
	assign acc = rx_valid_i && rx_ready_o;
	assign line_err = rx_frame_err_i || rx_overrun_err_i;
	assign push_done = push_v_reg && q_in_ready;
	assign rec_sum_next = rec_sum_reg + rx_data_i;

	loader_txq #(
		.WIDTH(`BYTE_W),
		.DEPTH(`TXQ_DEPTH),
		.AW(`TXQ_AW)
	) u_txq (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.in_valid_i(push_v_reg),
		.in_ready_o(q_in_ready),
		.in_data_i(push_d_reg),
		.out_valid_o(q_out_valid),
		.out_ready_i(q_out_ready),
		.out_data_o(q_out_data)
	);

	// =============================================
	// output stage: registered copy of the queue head
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
		end else if (ce_i && q_out_ready) begin
			tx_valid_o <= q_out_valid;
			tx_data_o <= q_out_data;
		end
	end

	// =============================================
	// receive handshake
	// ready drops for a cycle after each byte and while a reply
	// is staged, so a staged byte is never overwritten; a full
	// queue therefore stalls the receiver
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			rx_ready_o <= 1'b0;
		end else if (ce_i) begin
			rx_ready_o <= takes_bytes(state_reg) && !acc && !push_v_reg && q_in_ready;
		end
	end

	// =============================================
	// sequencer
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			state_reg <= S_SYNC1;
			cnt_reg <= 3'h0;
			addr_reg <= 48'h0;
			err_code_reg <= 8'h00;
			err_cnt_reg <= 2'h0;
			push_v_reg <= 1'b0;
			push_d_reg <= 8'h00;
			rec_pos_reg <= `REC_POS_MARK;
			rec_len_reg <= 8'h00;
			rec_cnt_reg <= 8'h00;
			rec_addr_reg <= 16'h0000;
			rec_type_reg <= 8'h00;
			rec_sum_reg <= 8'h00;
			sum_reg <= 16'h0000;
			first_seen_reg <= 1'b0;
			start_addr_reg <= 16'h0000;
			pwd_idx_o <= 8'h00;
			ram_we_o <= 1'b0;
			ram_addr_o <= 16'h0000;
			ram_wdata_o <= 8'h00;
			jump_o <= 1'b0;
			jump_addr_o <= 16'h0000;
			idle_o <= 1'b0;
		end else if (ce_i) begin
			ram_we_o <= 1'b0;
			jump_o <= 1'b0;
			if (push_done) begin
				push_v_reg <= 1'b0;
			end
			case (state_reg)
				// first matching byte; baud is tuned by the receiver
				S_SYNC1: begin
					if (acc) begin
						if (!line_err && (rx_data_i == `MATCH1_A || rx_data_i == `MATCH1_B)) begin
							push_v_reg <= 1'b1;
							push_d_reg <= rx_data_i;
							state_reg <= S_SYNC2;
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				// second matching byte at the tuned rate
				S_SYNC2: begin
					if (acc) begin
						if (!line_err && (rx_data_i == `MATCH2_A || rx_data_i == `MATCH2_B)) begin
							push_v_reg <= 1'b1;
							push_d_reg <= rx_data_i;
							state_reg <= S_CMD;
						end else begin
							state_reg <= S_IDLE;
						end
					end
				end
				// command byte: echo or start the error burst
				S_CMD: begin
					if (acc) begin
						if (!line_err && rx_data_i == `CMD_RAM_LOAD) begin
							push_v_reg <= 1'b1;
							push_d_reg <= rx_data_i;
							cnt_reg <= 3'h0;
							state_reg <= S_ADDR;
						end else begin
							err_code_reg <= line_err_code(rx_frame_err_i, rx_overrun_err_i);
							err_cnt_reg <= 2'h0;
							state_reg <= S_ERR;
						end
					end
				end
				// error code three times, one staged byte at a time
				S_ERR: begin
					if (!push_v_reg || push_done) begin
						if (err_cnt_reg == `ERR_REPEAT) begin
							state_reg <= S_IDLE;
						end else begin
							push_v_reg <= 1'b1;
							push_d_reg <= err_code_reg;
							err_cnt_reg <= err_cnt_reg + 2'h1;
						end
					end
				end
				// six silent address bytes, high byte first
				S_ADDR: begin
					if (acc) begin
						if (line_err) begin
							state_reg <= S_IDLE;
						end else begin
							addr_reg <= {addr_reg[39:0], rx_data_i};
							cnt_reg <= cnt_reg + 3'h1;
						end
					end else if (cnt_reg == `ADDR_BYTES) begin
						// addresses are checked even for a blank part
						if (addr_reg[47:24] != exp_cnt_addr_i || addr_reg[23:0] != exp_cmp_addr_i) begin
							state_reg <= S_IDLE;
						end else if (secure_i) begin
							state_reg <= S_IDLE;
						end else if (blank_i) begin
							state_reg <= S_REC;
						end else if (pwd_len_i == 8'h00) begin
							state_reg <= S_IDLE;
						end else begin
							pwd_idx_o <= 8'h00;
							state_reg <= S_PWD;
						end
						cnt_reg <= 3'h0;
					end
				end
				// password string compared byte by byte, no reply
				S_PWD: begin
					if (acc) begin
						if (line_err) begin
							state_reg <= S_IDLE;
						end else if (rx_data_i != pwd_byte_i) begin
							state_reg <= S_IDLE;
						end else if (pwd_idx_o == pwd_len_i - 8'h01) begin
							state_reg <= S_REC;
						end else begin
							pwd_idx_o <= pwd_idx_o + 8'h01;
						end
					end
				end
				// image records, silently written to RAM
				S_REC: begin
					if (acc) begin
						if (line_err) begin
							state_reg <= S_IDLE;
						end else begin
							case (rec_pos_reg)
								`REC_POS_MARK: begin
									if (rx_data_i == `REC_MARK) begin
										rec_sum_reg <= 8'h00;
										rec_pos_reg <= `REC_POS_LEN;
									end else begin
										state_reg <= S_IDLE;
									end
								end
								`REC_POS_LEN: begin
									rec_len_reg <= rx_data_i;
									rec_sum_reg <= rec_sum_next;
									rec_pos_reg <= `REC_POS_AHI;
								end
								`REC_POS_AHI: begin
									rec_addr_reg[15:8] <= rx_data_i;
									rec_sum_reg <= rec_sum_next;
									rec_pos_reg <= `REC_POS_ALO;
								end
								`REC_POS_ALO: begin
									rec_addr_reg[7:0] <= rx_data_i;
									rec_sum_reg <= rec_sum_next;
									rec_pos_reg <= `REC_POS_TYPE;
								end
								`REC_POS_TYPE: begin
									rec_type_reg <= rx_data_i;
									rec_sum_reg <= rec_sum_next;
									rec_cnt_reg <= 8'h00;
									if (rx_data_i != `REC_TYPE_DATA && rx_data_i != `REC_TYPE_END) begin
										state_reg <= S_IDLE;
									end else if (rec_len_reg == 8'h00 || rx_data_i == `REC_TYPE_END) begin
										rec_pos_reg <= `REC_POS_SUM;
									end else begin
										rec_pos_reg <= `REC_POS_DATA;
									end
								end
								`REC_POS_DATA: begin
									// each data byte goes straight to RAM
									ram_we_o <= 1'b1;
									ram_addr_o <= rec_addr_reg;
									ram_wdata_o <= rx_data_i;
									rec_addr_reg <= rec_addr_reg + 16'h0001;
									rec_sum_reg <= rec_sum_next;
									sum_reg <= sum_reg + {8'h00, rx_data_i};
									if (!first_seen_reg) begin
										first_seen_reg <= 1'b1;
										start_addr_reg <= rec_addr_reg;
									end
									rec_cnt_reg <= rec_cnt_reg + 8'h01;
									if (rec_cnt_reg == rec_len_reg - 8'h01) begin
										rec_pos_reg <= `REC_POS_SUM;
									end
								end
								`REC_POS_SUM: begin
									// record bytes must sum to zero with the check byte
									rec_pos_reg <= `REC_POS_MARK;
									if (rec_sum_next != 8'h00) begin
										state_reg <= S_IDLE;
									end else if (rec_type_reg == `REC_TYPE_END) begin
										state_reg <= S_SUMH;
									end
								end
								default: begin
									state_reg <= S_IDLE;
								end
							endcase
						end
					end
				end
				// checksum, high byte then low byte
				S_SUMH: begin
					if (!push_v_reg || push_done) begin
						push_v_reg <= 1'b1;
						push_d_reg <= sum_reg[15:8];
						state_reg <= S_SUML;
					end
				end
				S_SUML: begin
					if (!push_v_reg || push_done) begin
						push_v_reg <= 1'b1;
						push_d_reg <= sum_reg[7:0];
						state_reg <= S_JUMP;
					end
				end
				// hand over only once the checksum has left the pins
				S_JUMP: begin
					if (!push_v_reg && !q_out_valid && !tx_valid_o) begin
						jump_o <= 1'b1;
						jump_addr_o <= start_addr_reg;
						state_reg <= S_IDLE;
					end
				end
				// dead until reset: nothing taken, only replies already queued still go out
				S_IDLE: begin
					idle_o <= 1'b1;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: sim/serial_boot_ram_loader_assertions.sv */
// concurrent checks on the ports of the boot RAM loader sequencer
module serial_boot_ram_loader_assertions (
	// clock and reset
	input wire clk_i,
	input wire rstn_i,
	input wire ce_i,
	// byte streams
	input wire rx_valid_i,
	input wire rx_ready_o,
	input wire tx_valid_o,
	input wire [7:0] tx_data_o,
	input wire tx_ready_i,
	// results
	input wire ram_we_o,
	input wire jump_o,
	input wire idle_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// =============================================
	// handshakes: a reply holds until taken, a take closes the door
	a_tx_held_stable: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("reply byte changed before taken");
	a_take_then_busy: assert property (rx_valid_i && rx_ready_o && ce_i |=> !rx_ready_o)
		else $error("ready stayed high after a take");
	// =============================================
	// idle is final until reset
	a_idle_no_take: assert property (idle_o |-> !rx_ready_o)
		else $error("byte accepted while idle");
	a_idle_stays_on: assert property (idle_o |=> idle_o)
		else $error("idle left without reset");
	a_idle_stays_silent: assert property (idle_o && !tx_valid_o |=> !tx_valid_o)
		else $error("reply started while idle");
	// =============================================
	// hand-off to loaded code and RAM write pulse
	a_jump_single_pulse: assert property (jump_o |=> !jump_o)
		else $error("jump pulse too long");
	a_jump_then_idle: assert property (jump_o |=> ##[0:2] idle_o)
		else $error("no idle after jump");
	a_jump_after_sum: assert property (jump_o |-> !tx_valid_o)
		else $error("jump before checksum left");
	a_write_single_pulse: assert property (ram_we_o |=> !ram_we_o)
		else $error("ram write pulse too long");
	c_jump: cover property (jump_o);
	c_write: cover property (ram_we_o);
	c_idle_silent: cover property (idle_o && !jump_o);
endmodule

bind serial_boot_ram_loader serial_boot_ram_loader_assertions i_serial_boot_ram_loader_assertions (
	.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .ram_we_o(ram_we_o),
	.jump_o(jump_o), .idle_o(idle_o));

/* File: sim/loader_partner.sv */
// external programming controller model: sends bytes, gathers replies
module loader_partner (
	// clock and pacing
	input wire clk_i,
	input wire slow_i,
	// bytes into the device
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_frame_err_o,
	output logic rx_overrun_err_o,
	input wire rx_ready_i,
	// replies from the device
	input wire tx_valid_i,
	input wire [7:0] tx_data_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got [$];
	// quiet line at start
	initial begin
		rx_valid_o = 0;
		rx_data_o = 8'h00;
		rx_frame_err_o = 0;
		rx_overrun_err_o = 0;
		tx_ready_o = 1;
	end
	// slow mode takes a reply only every other cycle, to stretch the fifo
	always @(posedge clk_i) tx_ready_o <= #1 slow_i ? ~tx_ready_o : 1'b1;
	// gather each reply at the edge that takes it
	always @(posedge clk_i) if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
	// one byte held until taken; line flags qualify it; released line shows the inverse
	task send(input logic [7:0] b, input logic fe, input logic oe, output logic ok);
		int n;
		n = 0;
		// let an edge pass first so valid never falls and rises in one step
		@(posedge clk_i);
		#1;
		rx_valid_o = 1;
		rx_data_o = b;
		rx_frame_err_o = fe;
		rx_overrun_err_o = oe;
		while (rx_ready_i !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		ok = n < 300;
		@(posedge clk_i);
		#1;
		rx_valid_o = 0;
		rx_data_o = ~b;
		rx_frame_err_o = 0;
		rx_overrun_err_o = 0;
	endtask
endmodule

/* File: sim/test_serial_boot_ram_loader.sv */
// self-checking bench for the serial boot RAM loader
`include "serial_boot_map.vh"
module test_serial_boot_ram_loader;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [23:0] CNT_ADDR = 24'h01fe20;
	localparam logic [23:0] CMP_ADDR = 24'h02fd40;
	logic clk_i, rstn_i, ce_i, rx_valid_i, rx_frame_err_i, rx_overrun_err_i, rx_ready_o, tx_valid_o, tx_ready_i;
	logic blank_i, secure_i, slow, ram_we_o, jump_o, idle_o, ok;
	logic [7:0] rx_data_i, tx_data_o, pwd_len_i, pwd_byte_i, pwd_idx_o, ram_wdata_o;
	logic [15:0] ram_addr_o, jump_addr_o, jaddr;
	logic [23:0] exp_cnt_addr_i, exp_cmp_addr_i;
	logic [7:0] pwd [0:1] = '{8'h5a, 8'ha5};
	logic [23:0] wr [$];
	int n_mismatch = 0;
	int tests_run = 0;
	int n_jump = 0;
	serial_boot_ram_loader i_serial_boot_ram_loader (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_frame_err_i(rx_frame_err_i),
		.rx_overrun_err_i(rx_overrun_err_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .blank_i(blank_i), .secure_i(secure_i),
		.exp_cnt_addr_i(exp_cnt_addr_i), .exp_cmp_addr_i(exp_cmp_addr_i), .pwd_len_i(pwd_len_i),
		.pwd_byte_i(pwd_byte_i), .pwd_idx_o(pwd_idx_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
		.ram_wdata_o(ram_wdata_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o), .idle_o(idle_o));
	loader_partner i_loader_partner (.clk_i(clk_i), .slow_i(slow), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .rx_frame_err_o(rx_frame_err_i), .rx_overrun_err_o(rx_overrun_err_i),
		.rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
	// =============================================
	// clock, password lookup, result monitors
	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	assign pwd_byte_i = pwd[pwd_idx_o[0]];
	always @(posedge clk_i) begin
		if (ram_we_o) wr.push_back({ram_addr_o, ram_wdata_o});
		if (jump_o) begin
			n_jump++;
			jaddr = jump_addr_o;
		end
	end
	// =============================================
	// shared tasks
	task check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task print_verdict;
		if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// every scenario starts from the reset pin, as a host would after an error
	task do_reset(input logic b, input logic s, input logic sl);
		rstn_i = 0;
		blank_i = b;
		secure_i = s;
		slow = sl;
		repeat (8) @(posedge clk_i);
		#1;
		rstn_i = 1;
		i_loader_partner.got.delete();
		wr.delete();
		n_jump = 0;
	endtask
	task put(input logic [7:0] b, input logic fe = 0, input logic oe = 0);
		i_loader_partner.send(b, fe, oe, ok);
		if (!ok) begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	task wait_idle;
		int n;
		for (n = 0; n < 400 && idle_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 400) begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	task addrs(input logic [47:0] a, input logic fe_last);
		for (int i = 0; i < 6; i++) put(a[47-8*i -: 8], fe_last && i == 5);
	endtask
	task rec(input logic [15:0] ad, input logic [7:0] typ, input logic [7:0] d[$]);
		logic [7:0] s;
		s = d.size() + ad[15:8] + ad[7:0] + typ;
		put(`REC_MARK);
		put(d.size());
		put(ad[15:8]);
		put(ad[7:0]);
		put(typ);
		foreach (d[i]) begin
			put(d[i]);
			s = s + d[i];
		end
		put(-s);
	endtask
	task txseen(input logic [7:0] e[$]);
		check(i_loader_partner.got.size(), e.size(), "reply count");
		foreach (e[i]) check(i_loader_partner.got[i], e[i], "reply byte");
	endtask
	// =============================================
	// scenarios
	task t_load(input logic [7:0] m1, input logic [7:0] m2, input logic b);
		do_reset(b, 0, b);
		put(m1);
		put(m2);
		put(`CMD_RAM_LOAD);
		addrs({CNT_ADDR, CMP_ADDR}, 0);
		if (!b) begin
			put(pwd[0]);
			put(pwd[1]);
		end
		rec(16'h8010, `REC_TYPE_DATA, '{8'haa, 8'h61});
		rec(16'h0000, `REC_TYPE_END, '{});
		wait_idle;
		txseen('{m1, m2, `CMD_RAM_LOAD, 8'h01, 8'h0b});
		check(wr.size(), 2, "ram writes");
		check(wr[0], {16'h8010, 8'haa}, "first write");
		check(wr[1], {16'h8011, 8'h61}, "second write");
		check(n_jump, 1, "jump count");
		check(jaddr, 16'h8010, "jump address");
	endtask
	// frame error, overrun, wrong code: each gives its code three times, then silence
	task t_cmd_err;
		logic [7:0] c;
		for (int k = 0; k < 3; k++) begin
			c = k == 0 ? `ERR_FRAME : k == 1 ? `ERR_OVERRUN : `ERR_COMMAND;
			do_reset(0, 0, 1);
			put(`MATCH1_A);
			put(`MATCH2_A);
			put(k == 2 ? 8'h40 : `CMD_RAM_LOAD, k == 0, k == 1);
			wait_idle;
			repeat (20) @(posedge clk_i);
			#1;
			txseen('{`MATCH1_A, `MATCH2_A, c, c, c});
		end
	endtask
	// wrong count address, wrong compare address, line error, security, bad password, bad record mark
	task t_pwd_err;
		for (int k = 0; k < 6; k++) begin
			do_reset(0, k == 3, 0);
			put(`MATCH1_B);
			put(`MATCH2_B);
			put(`CMD_RAM_LOAD);
			addrs({CNT_ADDR ^ (k == 0), CMP_ADDR ^ (k == 1)}, k == 2);
			if (k == 4) put(8'h00);
			if (k == 5) begin
				put(pwd[0]);
				put(pwd[1]);
				put(8'h3b);
			end
			wait_idle;
			txseen('{`MATCH1_B, `MATCH2_B, `CMD_RAM_LOAD});
			check(wr.size(), 0, "no writes after error");
		end
	endtask
	// a good first byte is echoed, a bad second one is met with silence
	task t_bad_match;
		do_reset(0, 0, 0);
		put(`MATCH1_B);
		put(8'h7a);
		wait_idle;
		txseen('{`MATCH1_B});
	endtask
	// =============================================
	// main sequence
	initial begin
		ce_i = 1;
		rstn_i = 0;
		blank_i = 0;
		secure_i = 0;
		slow = 0;
		exp_cnt_addr_i = CNT_ADDR;
		exp_cmp_addr_i = CMP_ADDR;
		pwd_len_i = 8'h02;
		t_load(`MATCH1_A, `MATCH2_A, 0);
		t_load(`MATCH1_B, `MATCH2_B, 1);
		t_cmd_err;
		t_pwd_err;
		t_bad_match;
		print_verdict;
	end
endmodule
